/* File: pkg/stc_pkg.sv */
package stc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] ADDR_FAST_DECAY_LIMITS = 4'h1;
    localparam logic [3:0] ADDR_MIN_ON_TIME = 4'h2;
    localparam logic [3:0] ADDR_MIN_OFF_TIME = 4'h3;
    localparam logic [3:0] ADDR_CONVERTER_RESULT = 4'h4;
    localparam logic [3:0] ADDR_OVERCURRENT_THRESHOLD = 4'h5;
    localparam logic [3:0] ADDR_STEP_MODE_CONFIG = 4'h6;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int FAST_DECAY_MSB = 7;
    localparam int FAST_DECAY_LSB = 4;
    localparam int FALL_STEP_MSB = 3;
    localparam int FALL_STEP_LSB = 0;
    localparam int SYNC_EN_BIT = 7;
    localparam int SYNC_SEL_MSB = 6;
    localparam int SYNC_SEL_LSB = 4;
    localparam int FIXED_ONE_BIT = 3;
    localparam int STEP_SEL_MSB = 2;
    localparam int STEP_SEL_LSB = 0;
    localparam int POSITION_SYNC_TOP = 7;
    localparam logic [2:0] SYNC_SEL_LAST = 3'h4;
    localparam logic [2:0] STEP_SEL_SIXTEENTH = 3'h4;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic [7:0] RST_FAST_DECAY_LIMITS = 8'h19;
    localparam logic [6:0] RST_MIN_ON_TIME = 7'h29;
    localparam logic [6:0] RST_MIN_OFF_TIME = 7'h29;
    localparam logic [4:0] RST_OVERCURRENT_THRESHOLD = 5'h08;
    localparam logic [7:0] RST_STEP_MODE_CONFIG = 8'h0f;
    localparam logic [8:0] RST_ELECTRICAL_POSITION = 9'h000;
    localparam logic [8:0] POSITION_SIXTEENTH_INC = 9'h008;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_FREQ_MHZ = 200;
    localparam int FAST_UNIT_NS = 2000;
    localparam int ONOFF_UNIT_NS = 500;
    localparam int FAST_UNIT_CYC = FAST_UNIT_NS * CLK_FREQ_MHZ / 1000;
    localparam int ONOFF_UNIT_CYC = ONOFF_UNIT_NS * CLK_FREQ_MHZ / 1000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } stc_req_s;

endpackage

/* File: logic/stc_timing_sync.sv */
`timescale 1ns/1ps
// Functional notes
// - Fast-decay upper nibble, fall-step lower nibble
// - Fast-decay codes give 2 us times (n+1)
// - Timing or step writes while running dropped, error
// - Minimum on-time is 0.5 us times (n+1)
// - Minimum off-time is 0.5 us times (n+1)
// - Converter result reports input as k/32
// - Converter result writes always dropped, error
// - Overcurrent threshold 31.25 mV times (n+1)
// - Step mode: sync enable, sync select, step select
// - Step select decode, top bit means sixteenth
// - Step mode change resets electrical position
// - Sync disabled: output low while command busy
// - Sync enabled: output carries selected clock
// - Sync select picks electrical position bit 7..3
// - Sync select 101..111 holds output low
// - Sync select valid only up to step select
// - Electrical position: step MSBs, sixteenths below
module stc_timing_sync #(
    parameter int CYC_W = 14
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire stc_pkg::stc_req_s i_req,
    input wire logic i_motor_running,
    input wire logic i_cmd_busy,
    input wire logic [4:0] i_converter_code,
    input wire logic i_step_pulse,
    input wire logic i_step_fwd,
    input wire logic i_err_clear,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic o_cmd_error,
    output logic o_busy_sync,
    output logic [8:0] o_electrical_position,
    output logic [2:0] o_step_mode,
    output logic [CYC_W-1:0] o_fast_decay_cycles,
    output logic [CYC_W-1:0] o_fall_step_cycles,
    output logic [CYC_W-1:0] o_min_on_cycles,
    output logic [CYC_W-1:0] o_min_off_cycles,
    output logic [4:0] o_overcurrent_threshold
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] fast_decay_limits;
        logic [6:0] min_on_time;
        logic [6:0] min_off_time;
        logic [4:0] converter_result;
        logic [4:0] overcurrent_threshold;
        logic [7:0] step_mode_config;
        logic [8:0] electrical_position;
        logic cmd_error;
        logic [7:0] rdata;
        logic rvalid;
        logic busy_sync;
        logic [2:0] step_mode;
        logic [CYC_W-1:0] fast_cyc;
        logic [CYC_W-1:0] fall_cyc;
        logic [CYC_W-1:0] on_cyc;
        logic [CYC_W-1:0] off_cyc;
    } stc_state_s;

    stc_state_s state_reg;
    stc_state_s state_next;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [CYC_W-1:0] code_to_cycles(input logic [6:0] code, input int unit);
        int prod;
        prod = (int'(code) + 1) * unit;
        return prod[CYC_W-1:0];
    endfunction

    // Codes with the top bit set all mean sixteenth step
    function automatic logic [2:0] step_decode(input logic [2:0] sel);
        return sel[2] ? stc_pkg::STEP_SEL_SIXTEENTH : sel;
    endfunction

    function automatic logic sync_valid(input logic [2:0] sync_sel, input logic [2:0] step_sel);
        return (sync_sel <= stc_pkg::SYNC_SEL_LAST) && (sync_sel <= step_decode(step_sel));
    endfunction

    logic guarded_addr;
    logic run_drop;
    logic adc_drop;
    logic step_wr_ok;
    logic [2:0] cur_sync_sel;
    logic [2:0] cur_step_sel;
    logic [8:0] el_inc;

    assign guarded_addr = (i_req.addr == stc_pkg::ADDR_FAST_DECAY_LIMITS)
        || (i_req.addr == stc_pkg::ADDR_MIN_ON_TIME)
        || (i_req.addr == stc_pkg::ADDR_MIN_OFF_TIME)
        || (i_req.addr == stc_pkg::ADDR_STEP_MODE_CONFIG);
    assign run_drop = i_req.wr && i_motor_running && guarded_addr;
    assign adc_drop = i_req.wr && (i_req.addr == stc_pkg::ADDR_CONVERTER_RESULT);
    assign step_wr_ok = i_req.wr && !i_motor_running && (i_req.addr == stc_pkg::ADDR_STEP_MODE_CONFIG);
    assign cur_sync_sel = state_reg.step_mode_config[stc_pkg::SYNC_SEL_MSB:stc_pkg::SYNC_SEL_LSB];
    assign cur_step_sel = state_reg.step_mode_config[stc_pkg::STEP_SEL_MSB:stc_pkg::STEP_SEL_LSB];
    // One step of the chosen resolution in sixteenths, placed above the zero bits
    assign el_inc = stc_pkg::POSITION_SIXTEENTH_INC
        << (stc_pkg::STEP_SEL_SIXTEENTH - step_decode(cur_step_sel));

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        state_next.rvalid = 1'b0;
        state_next.converter_result = i_converter_code;

        if (i_step_pulse)
        begin
            if (i_step_fwd)
            begin
                state_next.electrical_position = 9'(state_reg.electrical_position + el_inc);
            end
            else
            begin
                state_next.electrical_position = 9'(state_reg.electrical_position - el_inc);
            end
        end

        // Set beats clear so a drop in the clearing cycle is kept
        if (i_err_clear)
        begin
            state_next.cmd_error = 1'b0;
        end
        if (run_drop || adc_drop)
        begin
            state_next.cmd_error = 1'b1;
        end

        if (i_req.wr && !run_drop)
        begin
            if (i_req.addr == stc_pkg::ADDR_FAST_DECAY_LIMITS)
            begin
                state_next.fast_decay_limits = i_req.wdata;
            end
            else if (i_req.addr == stc_pkg::ADDR_MIN_ON_TIME)
            begin
                state_next.min_on_time = i_req.wdata[6:0];
            end
            else if (i_req.addr == stc_pkg::ADDR_MIN_OFF_TIME)
            begin
                state_next.min_off_time = i_req.wdata[6:0];
            end
            else if (i_req.addr == stc_pkg::ADDR_OVERCURRENT_THRESHOLD)
            begin
                state_next.overcurrent_threshold = i_req.wdata[4:0];
            end
            else if (i_req.addr == stc_pkg::ADDR_STEP_MODE_CONFIG)
            begin
                // Fixed bit stored as one whatever the host sends
                state_next.step_mode_config = i_req.wdata;
                state_next.step_mode_config[stc_pkg::FIXED_ONE_BIT] = 1'b1;
            end
        end

        if (step_wr_ok && (step_decode(i_req.wdata[stc_pkg::STEP_SEL_MSB:stc_pkg::STEP_SEL_LSB])
            != step_decode(cur_step_sel)))
        begin
            state_next.electrical_position = stc_pkg::RST_ELECTRICAL_POSITION;
        end

        if (i_req.rd)
        begin
            state_next.rvalid = 1'b1;
            if (i_req.addr == stc_pkg::ADDR_FAST_DECAY_LIMITS)
            begin
                state_next.rdata = state_reg.fast_decay_limits;
            end
            else if (i_req.addr == stc_pkg::ADDR_MIN_ON_TIME)
            begin
                state_next.rdata = {1'b0, state_reg.min_on_time};
            end
            else if (i_req.addr == stc_pkg::ADDR_MIN_OFF_TIME)
            begin
                state_next.rdata = {1'b0, state_reg.min_off_time};
            end
            else if (i_req.addr == stc_pkg::ADDR_CONVERTER_RESULT)
            begin
                state_next.rdata = {3'h0, state_reg.converter_result};
            end
            else if (i_req.addr == stc_pkg::ADDR_OVERCURRENT_THRESHOLD)
            begin
                state_next.rdata = {3'h0, state_reg.overcurrent_threshold};
            end
            else if (i_req.addr == stc_pkg::ADDR_STEP_MODE_CONFIG)
            begin
                state_next.rdata = state_reg.step_mode_config;
            end
            else
            begin
                state_next.rdata = 8'h00;
            end
        end

        // Pin level: low means busy, or the selected position bit
        if (!state_reg.step_mode_config[stc_pkg::SYNC_EN_BIT])
        begin
            state_next.busy_sync = !i_cmd_busy;
        end
        else if (sync_valid(cur_sync_sel, cur_step_sel))
        begin
            state_next.busy_sync =
                state_reg.electrical_position[stc_pkg::POSITION_SYNC_TOP - int'(cur_sync_sel)];
        end
        else
        begin
            state_next.busy_sync = 1'b0;
        end

        state_next.step_mode = step_decode(state_next.step_mode_config[2:0]);
        state_next.fast_cyc = code_to_cycles({3'h0, state_next.fast_decay_limits[7:4]},
            stc_pkg::FAST_UNIT_CYC);
        state_next.fall_cyc = code_to_cycles({3'h0, state_next.fast_decay_limits[3:0]},
            stc_pkg::FAST_UNIT_CYC);
        state_next.on_cyc = code_to_cycles(state_next.min_on_time, stc_pkg::ONOFF_UNIT_CYC);
        state_next.off_cyc = code_to_cycles(state_next.min_off_time, stc_pkg::ONOFF_UNIT_CYC);
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_nrst)
        begin
            state_reg <= '0;
            state_reg.fast_decay_limits <= stc_pkg::RST_FAST_DECAY_LIMITS;
            state_reg.min_on_time <= stc_pkg::RST_MIN_ON_TIME;
            state_reg.min_off_time <= stc_pkg::RST_MIN_OFF_TIME;
            state_reg.overcurrent_threshold <= stc_pkg::RST_OVERCURRENT_THRESHOLD;
            state_reg.step_mode_config <= stc_pkg::RST_STEP_MODE_CONFIG;
            state_reg.electrical_position <= stc_pkg::RST_ELECTRICAL_POSITION;
            state_reg.busy_sync <= 1'b1;
            state_reg.step_mode <= stc_pkg::STEP_SEL_SIXTEENTH;
            state_reg.fast_cyc <= CYC_W'(stc_pkg::FAST_UNIT_CYC * 2);
            state_reg.fall_cyc <= CYC_W'(stc_pkg::FAST_UNIT_CYC * 10);
            state_reg.on_cyc <= CYC_W'(stc_pkg::ONOFF_UNIT_CYC * 42);
            state_reg.off_cyc <= CYC_W'(stc_pkg::ONOFF_UNIT_CYC * 42);
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign o_rdata = state_reg.rdata;
    assign o_rvalid = state_reg.rvalid;
    assign o_cmd_error = state_reg.cmd_error;
    assign o_busy_sync = state_reg.busy_sync;
    assign o_electrical_position = state_reg.electrical_position;
    assign o_step_mode = state_reg.step_mode;
    assign o_fast_decay_cycles = state_reg.fast_cyc;
    assign o_fall_step_cycles = state_reg.fall_cyc;
    assign o_min_on_cycles = state_reg.on_cyc;
    assign o_min_off_cycles = state_reg.off_cyc;
    assign o_overcurrent_threshold = state_reg.overcurrent_threshold;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    sequence seq_run_fast_write;
        i_req.wr && i_motor_running && (i_req.addr == stc_pkg::ADDR_FAST_DECAY_LIMITS);
    endsequence

    sequence seq_on_write;
        i_req.wr && !i_motor_running && (i_req.addr == stc_pkg::ADDR_MIN_ON_TIME);
    endsequence

    sequence seq_fast_write;
        i_req.wr && !i_motor_running && (i_req.addr == stc_pkg::ADDR_FAST_DECAY_LIMITS);
    endsequence

    sequence seq_off_write;
        i_req.wr && !i_motor_running && (i_req.addr == stc_pkg::ADDR_MIN_OFF_TIME);
    endsequence

    sequence seq_step_write;
        i_req.wr && !i_motor_running && (i_req.addr == stc_pkg::ADDR_STEP_MODE_CONFIG);
    endsequence

    chk_run_write_drop: assert property (seq_run_fast_write |=>
        $stable(state_reg.fast_decay_limits) && o_cmd_error)
        else $error("write while running not dropped");

    chk_adc_write_err: assert property (i_req.wr && (i_req.addr == stc_pkg::ADDR_CONVERTER_RESULT)
        |=> o_cmd_error)
        else $error("converter result write did not flag");

    chk_err_sticky: assert property (o_cmd_error && !i_err_clear |=> o_cmd_error)
        else $error("command error dropped early");

    chk_on_time_cycles: assert property (seq_on_write ##1 !(i_req.wr && i_req.addr ==
        stc_pkg::ADDR_MIN_ON_TIME) |-> o_min_on_cycles == CYC_W'((int'($past(i_req.wdata[6:0], 1)) + 1) * 100))
        else $error("on-time cycles wrong");

    chk_busy_level: assert property (!state_reg.step_mode_config[7] && i_cmd_busy |=> !o_busy_sync)
        else $error("busy not low during command");

    chk_sync_unused: assert property (state_reg.step_mode_config[7] && state_reg.step_mode_config[6]
        && (state_reg.step_mode_config[5] || state_reg.step_mode_config[4]) |=> !o_busy_sync)
        else $error("unused sync select not low");

    chk_sync_na_low: assert property (state_reg.step_mode_config[7] && !state_reg.step_mode_config[2]
        && (cur_sync_sel > cur_step_sel) |=> !o_busy_sync)
        else $error("invalid sync select not low");

    chk_sync_copy: assert property (state_reg.step_mode_config[7] && (cur_sync_sel == 3'h0)
        |=> o_busy_sync == $past(state_reg.electrical_position[7]))
        else $error("sync does not copy position bit");

    chk_mode_reset: assert property (step_wr_ok
        && (step_decode(i_req.wdata[2:0]) != step_decode(cur_step_sel)) |=> o_electrical_position == 9'h000)
        else $error("position not reset on mode change");

    // Counts recomputed from the written code, not from the helper function
    chk_fast_cycles: assert property (seq_fast_write ##1 !(i_req.wr && i_req.addr ==
        stc_pkg::ADDR_FAST_DECAY_LIMITS) |-> o_fast_decay_cycles ==
        CYC_W'((int'($past(i_req.wdata[7:4], 1)) + 1) * stc_pkg::FAST_UNIT_CYC)
        && o_fall_step_cycles == CYC_W'((int'($past(i_req.wdata[3:0], 1)) + 1) * stc_pkg::FAST_UNIT_CYC))
        else $error("fast decay cycles wrong");

    chk_off_time_cycles: assert property (seq_off_write ##1 !(i_req.wr && i_req.addr ==
        stc_pkg::ADDR_MIN_OFF_TIME) |-> o_min_off_cycles == CYC_W'((int'($past(i_req.wdata[6:0], 1)) + 1) * 100))
        else $error("off-time cycles wrong");

    chk_step_decode: assert property (seq_step_write |=> o_step_mode ==
        ($past(i_req.wdata[2]) ? stc_pkg::STEP_SEL_SIXTEENTH : $past(i_req.wdata[2:0])))
        else $error("step mode decode wrong");

    chk_pos_forward: assert property (i_step_pulse && i_step_fwd && !step_wr_ok |=>
        o_electrical_position == 9'($past(o_electrical_position) + (9'h008 << (3'h4 - $past(o_step_mode)))))
        else $error("position did not advance one step");

    chk_pos_backward: assert property (i_step_pulse && !i_step_fwd && !step_wr_ok |=>
        o_electrical_position == 9'($past(o_electrical_position) - (9'h008 << (3'h4 - $past(o_step_mode)))))
        else $error("position did not go back one step");

    chk_run_on_keep: assert property (i_req.wr && i_motor_running
        && (i_req.addr == stc_pkg::ADDR_MIN_ON_TIME) |=> $stable(o_min_on_cycles) && o_cmd_error)
        else $error("on-time write while running not dropped");

    chk_run_step_keep: assert property (i_req.wr && i_motor_running
        && (i_req.addr == stc_pkg::ADDR_STEP_MODE_CONFIG) |=> $stable(state_reg.step_mode_config))
        else $error("step mode write while running not dropped");

endmodule // stc_timing_sync

/* File: tb/stc_host_model.sv */
`timescale 1ns/1ps
module stc_host_model (
    input wire logic i_sys_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output stc_pkg::stc_req_s o_req
);
    // ****************************************
    // Register access of the host
    // ****************************************
    initial o_req = '0;

    // Released lines show the inverse, so a stale value can never pass
    task automatic release_bus();
        o_req.wr <= 1'b0;
        o_req.rd <= 1'b0;
        o_req.addr <= ~o_req.addr;
        o_req.wdata <= ~o_req.wdata;
    endtask

    task automatic write(input logic [3:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_sys_clk);
        release_bus();
    endtask

    task automatic read(input logic [3:0] a, output logic [7:0] d, output logic v);
        @(negedge i_sys_clk);
        o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~o_req.wdata};
        @(negedge i_sys_clk);
        d = i_rdata;
        v = i_rvalid;
        release_bus();
    endtask

    task automatic write_step(input logic en, input logic [2:0] sel, input logic [2:0] st);
        write(stc_pkg::ADDR_STEP_MODE_CONFIG, {en, sel, 1'b1, st});
    endtask
endmodule // stc_host_model

/* File: tb/stc_timing_sync_tb.sv */
`timescale 1ns/1ps
module stc_timing_sync_tb;
    logic clk;
    logic nrst;
    stc_pkg::stc_req_s req;
    logic running;
    logic busy;
    logic [4:0] conv;
    logic step_pulse;
    logic step_fwd;
    logic err_clear;
    logic [7:0] rdata;
    logic rvalid;
    logic cmd_error;
    logic busy_sync;
    logic [8:0] pos;
    logic [2:0] mode;
    logic [13:0] fast;
    logic [13:0] fall;
    logic [13:0] on_cyc;
    logic [13:0] off_cyc;
    logic [4:0] ocd;
    logic [7:0] exp_reg [0:7];
    logic [8:0] pos_exp;
    logic [2:0] mode_exp;
    int mismatches;
    int check_count;

    stc_timing_sync stc_timing_sync_i (
        .i_sys_clk(clk), .i_nrst(nrst), .i_req(req), .i_motor_running(running), .i_cmd_busy(busy),
        .i_converter_code(conv), .i_step_pulse(step_pulse), .i_step_fwd(step_fwd), .i_err_clear(err_clear),
        .o_rdata(rdata), .o_rvalid(rvalid), .o_cmd_error(cmd_error), .o_busy_sync(busy_sync),
        .o_electrical_position(pos), .o_step_mode(mode), .o_fast_decay_cycles(fast),
        .o_fall_step_cycles(fall), .o_min_on_cycles(on_cyc), .o_min_off_cycles(off_cyc),
        .o_overcurrent_threshold(ocd));

    stc_host_model stc_host_model_i (.i_sys_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));

    // ****************************************
    // Shared checks and drivers
    // ****************************************
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        stc_host_model_i.read(a, d, v);
        chk({13'h0, v}, 14'h1);
        chk({6'h0, d}, {6'h0, exp});
    endtask

    task automatic chk_outputs();
        chk(fast, 14'((exp_reg[1][7:4] + 1) * stc_pkg::FAST_UNIT_CYC));
        chk(fall, 14'((exp_reg[1][3:0] + 1) * stc_pkg::FAST_UNIT_CYC));
        chk(on_cyc, 14'((exp_reg[2] + 1) * stc_pkg::ONOFF_UNIT_CYC));
        chk(off_cyc, 14'((exp_reg[3] + 1) * stc_pkg::ONOFF_UNIT_CYC));
        chk({9'h0, ocd}, {9'h0, exp_reg[5][4:0]});
        for (int a = 0; a < 8; a++)
            rd_chk(a[3:0], (a == 4) ? {3'h0, conv} : exp_reg[a]);
    endtask

    task automatic wr_exp(input logic [3:0] a, input logic [7:0] d, input logic refused);
        stc_host_model_i.write(a, d);
        if (!refused && a inside {[1:3], 5})
            exp_reg[a] = d & ((a == 2 || a == 3) ? 8'h7f : (a == 5) ? 8'h1f : 8'hff);
        chk({13'h0, cmd_error}, {13'h0, refused});
        chk_outputs();
        chk({13'h0, cmd_error}, {13'h0, refused});
        @(negedge clk);
        err_clear = 1'b1;
        @(negedge clk);
        err_clear = 1'b0;
        chk({13'h0, cmd_error}, 14'h0);
    endtask

    task automatic set_step(input logic en, input logic [2:0] sel, input logic [2:0] st);
        logic [2:0] d;
        d = st[2] ? 3'h4 : st;
        if (d != mode_exp)
            pos_exp = 9'h000;
        mode_exp = d;
        exp_reg[6] = {en, sel, 1'b1, st};
        stc_host_model_i.write_step(en, sel, st);
        chk({11'h0, mode}, {11'h0, mode_exp});
        chk({5'h0, pos}, {5'h0, pos_exp});
    endtask

    task automatic step_once();
        @(negedge clk);
        step_pulse = 1'b1;
        @(negedge clk);
        step_pulse = 1'b0;
        if (step_fwd)
            pos_exp = pos_exp + (9'h008 << (3'd4 - mode_exp));
        else
            pos_exp = pos_exp - (9'h008 << (3'd4 - mode_exp));
        chk({5'h0, pos}, {5'h0, pos_exp});
    endtask

    task automatic final_report();
        $display("Checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        exp_reg = '{8'h00, stc_pkg::RST_FAST_DECAY_LIMITS, {1'b0, stc_pkg::RST_MIN_ON_TIME},
                    {1'b0, stc_pkg::RST_MIN_OFF_TIME}, 8'h00, {3'h0, stc_pkg::RST_OVERCURRENT_THRESHOLD},
                    stc_pkg::RST_STEP_MODE_CONFIG, 8'h00};
        pos_exp = 9'h000;
        mode_exp = 3'h4;
        chk({13'h0, busy_sync}, 14'h1);
        chk_outputs();
    endtask

    task automatic t_timing();
        wr_exp(4'h1, 8'hf0, 1'b0);
        wr_exp(4'h2, 8'hff, 1'b0);
        wr_exp(4'h3, 8'h00, 1'b0);
        wr_exp(4'h5, 8'h1f, 1'b0);
        wr_exp(4'h7, 8'h55, 1'b0);
    endtask

    task automatic t_refuse();
        running = 1'b1;
        wr_exp(4'h1, 8'h3c, 1'b1);
        wr_exp(4'h2, 8'h11, 1'b1);
        wr_exp(4'h3, 8'h22, 1'b1);
        wr_exp(4'h6, 8'h8a, 1'b1);
        wr_exp(4'h5, 8'h11, 1'b0);
        running = 1'b0;
        wr_exp(4'h4, 8'h1f, 1'b1);
        conv = 5'h1f;
        rd_chk(4'h4, 8'h1f);
    endtask

    task automatic t_step_modes();
        for (int s = 0; s < 8; s++)
        begin
            step_once();
            set_step(1'b0, 3'h0, s[2:0]);
        end
        step_fwd = 1'b0;
        repeat (2) step_once();
        step_fwd = 1'b1;
        busy = 1'b1;
        repeat (2) @(negedge clk);
        chk({13'h0, busy_sync}, 14'h0);
        busy = 1'b0;
        repeat (2) @(negedge clk);
        chk({13'h0, busy_sync}, 14'h1);
    endtask

    // Every source and every step mode, the invalid pairs included
    task automatic t_sync();
        for (int st = 0; st < 5; st++)
            for (int k = 0; k < 8; k++)
            begin
                set_step(1'b1, k[2:0], st[2:0]);
                repeat (20)
                begin
                    step_once();
                    @(negedge clk);
                    chk({13'h0, busy_sync}, {13'h0, (k <= 4 && k <= st) ? pos_exp[7 - k] : 1'b0});
                end
            end
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Whole run needs some 14 us; a hang is cut at 200 us
    initial
    begin
        #200000;
        mismatches++;
        final_report();
    end

    initial
    begin
        mismatches = 0;
        check_count = 0;
        nrst = 1'b0;
        running = 1'b0;
        busy = 1'b0;
        conv = 5'h0a;
        step_pulse = 1'b0;
        step_fwd = 1'b1;
        err_clear = 1'b0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        t_reset();
        t_timing();
        t_refuse();
        t_step_modes();
        t_sync();
        final_report();
    end
endmodule // stc_timing_sync_tb
